// ===== logic/acc_ctrl.sv
// Conversion control: start, busy, read gating, configuration and register slave
//
// The address map and the AXI4-Lite register port were left to the implementer.
`include "acc_params.svh"
`default_nettype none

// ****************************************************************
// Functional notes
// ****************************************************************
// Functional notes
// - Software mode: config bits shift in on configuration clock edges.
// - Edge invert input picks rising or falling shift clock edge.
// - Shifting only while config port select asserted in software mode.
// - Busy rises at conversion start, falls when result latched.
// - Serial master read-after-convert mode lengthens busy time.
// - Bipolar and span inputs select one of four input ranges.
// - Result outputs enabled only while select and read both low.
// - Slave serial mode: select gates external data clock, not config port.
// - Reset pin high holds reset and aborts conversion without result.
// - Reset falling edge zeroes result when straight binary selected.
// - Reset falling edge clears the serial configuration register.
// - Power-down finishes current conversion, then blocks new ones.
// - Digital interface stays working during power-down.
// - Convert-start falling edge enters hold and starts conversion.
// - Config source low uses shift register, high uses level pins.

module acc_ctrl (
   input wire logic clk_sys,
   input wire logic nrst,
   input wire logic [`ACC_ADDR_W-1:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [`ACC_ADDR_W-1:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   input wire logic convert_start_n,
   input wire logic reset_in,
   input wire logic cs_n,
   input wire logic rd_n,
   input wire acc_pkg::acc_mode_pins_t mode_pins,
   input wire acc_pkg::acc_cfg_port_t cfg_port,
   input wire logic ext_data_clock,
   input wire logic [`ACC_DATA_W-1:0] sample_code,
   output logic busy,
   output logic sample_hold,
   output logic [`ACC_DATA_W-1:0] data_out,
   output logic data_oe,
   output logic gated_data_clock,
   output acc_pkg::acc_range_t range_sel,
   output logic power_down_active
);

   localparam int CONV_CYC_I = `ACC_CONV_CYC;
   localparam int TOT_CYC_I = `ACC_CONV_CYC + `ACC_EXT_CYC;

   acc_pkg::acc_main_st_t st_r;
   acc_pkg::acc_main_st_t st_nxt;
   acc_pkg::acc_cfg_reg_t cfg_q;
   logic [`ACC_SYNC_W-1:0] pin_raw;
   logic [`ACC_SYNC_W-1:0] pin_s;
   logic cnv_s;
   logic rst_s;
   logic pd_pin_s;
   logic sclk_s;
   logic sdin_s;
   logic ssel_s;
   logic cnv_fall;
   logic rst_fall;
   logic sw_mode;
   logic pd_eff;
   logic obf_eff;
   logic bip_eff;
   logic span_eff;
   logic ext_busy;
   logic slave_mode;
   logic wr_do;
   logic sw_start;
   logic start_req;

   // ****************************************************************
   // Decoders
   // ****************************************************************
   function automatic logic acc_addr_hit(input logic [`ACC_ADDR_W-1:0] a);
      acc_addr_hit = (a == `ACC_ADDR_CTRL) || (a == `ACC_ADDR_STATUS) || (a == `ACC_ADDR_RESULT) ||
                     (a == `ACC_ADDR_CFG) || (a == `ACC_ADDR_COUNT);
   endfunction

   function automatic acc_pkg::acc_range_t acc_range_dec(input logic bip, input logic span);
      acc_range_dec = acc_pkg::acc_range_t'({bip, span});
   endfunction

   // ****************************************************************
   // Pin synchronisation and configuration port
   // ****************************************************************
   assign pin_raw = {convert_start_n, reset_in, mode_pins.power_down_in, cfg_port.config_shift_clock,
                     cfg_port.config_serial_input, cfg_port.config_port_select};

   acc_sync u_sync (
      .clk_sys(clk_sys),
      .nrst(nrst),
      .d(pin_raw),
      .q(pin_s)
   );

   assign {cnv_s, rst_s, pd_pin_s, sclk_s, sdin_s, ssel_s} = pin_s;
   assign cnv_fall = st_r.cnv_prev & ~cnv_s;
   assign rst_fall = st_r.rst_prev & ~rst_s;
   assign sw_mode = mode_pins.serial_parallel_select & ~mode_pins.config_source_select;

   acc_cfg_shift u_cfg (
      .clk_sys(clk_sys),
      .nrst(nrst),
      .sclk(sclk_s),
      .sdin(sdin_s),
      .invert(cfg_port.config_clock_edge_invert),
      .enable(ssel_s & sw_mode),
      .clear(rst_fall),
      .cfg_q(cfg_q)
   );

   // ****************************************************************
   // Effective configuration
   // ****************************************************************
   assign pd_eff = (mode_pins.config_source_select ? pd_pin_s : cfg_q.pd) | st_r.ctrl[`ACC_CTRL_PD_BIT];
   assign obf_eff = mode_pins.config_source_select ? mode_pins.output_binary_format : cfg_q.obf;
   assign bip_eff = mode_pins.config_source_select ? mode_pins.range_bipolar_select : cfg_q.bipolar;
   assign span_eff = mode_pins.config_source_select ? mode_pins.range_span_select : cfg_q.span;
   assign ext_busy = mode_pins.serial_parallel_select & ~mode_pins.clock_source_select &
                     ~mode_pins.read_during_convert_select;
   assign slave_mode = mode_pins.serial_parallel_select & mode_pins.clock_source_select;

   assign wr_do = st_r.aw_got & st_r.w_got & ~st_r.bvalid;
   assign sw_start = wr_do & (st_r.aw_addr == `ACC_ADDR_CTRL) & st_r.w_strb[0] &
                     st_r.w_data[`ACC_CTRL_START_BIT];
   assign start_req = cnv_fall | sw_start;

   // ****************************************************************
   // Next state
   // ****************************************************************
   always_comb begin
      st_nxt = st_r;
      st_nxt.cnv_prev = cnv_s;
      st_nxt.rst_prev = rst_s;
      st_nxt.oe = ~cs_n & ~rd_n;
      st_nxt.gclk = ext_data_clock & ~cs_n & slave_mode;
      st_nxt.range = acc_range_dec(bip_eff, span_eff);
      st_nxt.pd_act = pd_eff;
      case (st_r.fsm)
         acc_pkg::ACC_ST_RESET: begin
            if (!rst_s) begin
               st_nxt.fsm = acc_pkg::ACC_ST_IDLE;
            end
         end
         acc_pkg::ACC_ST_IDLE: begin
            if (start_req && !pd_eff) begin
               st_nxt.fsm = acc_pkg::ACC_ST_CONV;
               st_nxt.busy = 1'b1;
               st_nxt.hold = 1'b1;
               st_nxt.held = sample_code;
               st_nxt.cnt = ext_busy ? `ACC_CNT_W'(TOT_CYC_I) : `ACC_CNT_W'(CONV_CYC_I);
            end
         end
         acc_pkg::ACC_ST_CONV: begin
            if (st_r.cnt == `ACC_CNT_W'(1)) begin
               st_nxt.fsm = acc_pkg::ACC_ST_IDLE;
               st_nxt.busy = 1'b0;
               st_nxt.hold = 1'b0;
               st_nxt.result = obf_eff ? st_r.held : (st_r.held ^ `ACC_TWOC_FLIP);
               st_nxt.count = st_r.count + 32'h1;
            end else begin
               st_nxt.cnt = st_r.cnt - `ACC_CNT_W'(1);
            end
         end
         default: begin
            st_nxt.fsm = acc_pkg::ACC_ST_RESET;
            st_nxt.busy = 1'b0;
            st_nxt.hold = 1'b0;
         end
      endcase
      if (rst_s) begin
         st_nxt.fsm = acc_pkg::ACC_ST_RESET;
         st_nxt.busy = 1'b0;
         st_nxt.hold = 1'b0;
         st_nxt.result = st_r.result;
         st_nxt.count = st_r.count;
      end
      if (rst_fall && obf_eff) begin
         st_nxt.result = '0;
      end
      // Write channel: address and data taken in either order
      if (s_axi_awvalid && !st_r.aw_got && !st_r.bvalid) begin
         st_nxt.aw_got = 1'b1;
         st_nxt.aw_addr = s_axi_awaddr;
      end
      if (s_axi_wvalid && !st_r.w_got && !st_r.bvalid) begin
         st_nxt.w_got = 1'b1;
         st_nxt.w_data = s_axi_wdata;
         st_nxt.w_strb = s_axi_wstrb;
      end
      if (wr_do) begin
         st_nxt.aw_got = 1'b0;
         st_nxt.w_got = 1'b0;
         st_nxt.bvalid = 1'b1;
         st_nxt.bresp = acc_addr_hit(st_r.aw_addr) ? `ACC_RESP_OKAY : `ACC_RESP_SLVERR;
         if (st_r.aw_addr == `ACC_ADDR_CTRL && st_r.w_strb[0]) begin
            st_nxt.ctrl = {st_r.w_data[`ACC_CTRL_PD_BIT], 1'b0};
         end
      end
      if (st_r.bvalid && s_axi_bready) begin
         st_nxt.bvalid = 1'b0;
      end
      // Read channel, live during power-down as well
      if (s_axi_arvalid && !st_r.rvalid) begin
         st_nxt.rvalid = 1'b1;
         st_nxt.rresp = acc_addr_hit(s_axi_araddr) ? `ACC_RESP_OKAY : `ACC_RESP_SLVERR;
         case (s_axi_araddr)
            `ACC_ADDR_CTRL: st_nxt.rdata = {30'h0, st_r.ctrl};
            `ACC_ADDR_STATUS: st_nxt.rdata = {24'h0, st_r.pd_act, st_r.range, st_r.hold, st_r.busy, st_r.fsm};
            `ACC_ADDR_RESULT: st_nxt.rdata = {18'h0, st_r.result};
            `ACC_ADDR_CFG: st_nxt.rdata = {24'h0, cfg_q};
            `ACC_ADDR_COUNT: st_nxt.rdata = st_r.count;
            default: st_nxt.rdata = 32'h0;
         endcase
      end else if (st_r.rvalid && s_axi_rready) begin
         st_nxt.rvalid = 1'b0;
      end
   end

   always_ff @(posedge clk_sys or negedge nrst) begin
      if (!nrst) begin
         st_r <= '0;
         st_r.fsm <= acc_pkg::ACC_ST_IDLE;
         st_r.ctrl <= `ACC_CTRL_RESET;
      end else begin
         st_r <= st_nxt;
      end
   end

   // ****************************************************************
   // Outputs
   // ****************************************************************
   assign s_axi_awready = ~st_r.aw_got & ~st_r.bvalid;
   assign s_axi_wready = ~st_r.w_got & ~st_r.bvalid;
   assign s_axi_bvalid = st_r.bvalid;
   assign s_axi_bresp = st_r.bresp;
   assign s_axi_arready = ~st_r.rvalid;
   assign s_axi_rvalid = st_r.rvalid;
   assign s_axi_rdata = st_r.rdata;
   assign s_axi_rresp = st_r.rresp;
   assign busy = st_r.busy;
   assign sample_hold = st_r.hold;
   assign data_out = st_r.result;
   assign data_oe = st_r.oe;
   assign gated_data_clock = st_r.gclk;
   assign range_sel = st_r.range;
   assign power_down_active = st_r.pd_act;

   // ****************************************************************
   // Checks
   // ****************************************************************
   logic [`ACC_CNT_W-1:0] bcnt_r;

   default clocking acc_cb @(posedge clk_sys);
   endclocking

   default disable iff (!nrst);

   always_ff @(posedge clk_sys or negedge nrst) begin
      if (!nrst) begin
         bcnt_r <= '0;
      end else begin
         bcnt_r <= busy ? bcnt_r + `ACC_CNT_W'(1) : '0;
      end
   end

   busy_rise_a: assert property (
      st_r.fsm == acc_pkg::ACC_ST_IDLE && cnv_fall && !pd_eff && !rst_s |=> busy && sample_hold)
      else $error("conversion did not start");

   busy_len_a: assert property (
      $fell(busy) && !$past(rst_s) |-> (bcnt_r == CONV_CYC_I || bcnt_r == TOT_CYC_I))
      else $error("busy interval has wrong length");

   busy_result_a: assert property (
      $fell(busy) && !$past(rst_s) |-> $past(st_r.fsm) == acc_pkg::ACC_ST_CONV && $changed(st_r.count))
      else $error("busy fell without latched result");

   pd_block_a: assert property (
      st_r.fsm == acc_pkg::ACC_ST_IDLE && pd_eff |=> !busy)
      else $error("conversion started in power-down");

   reset_abort_a: assert property (
      rst_s |=> !busy && !sample_hold && $stable(st_r.count))
      else $error("reset did not abort conversion");

   rst_zero_a: assert property (
      rst_fall && obf_eff |=> data_out == '0)
      else $error("result not zeroed on reset release");

   oe_gate_a: assert property (
      ##1 data_oe == (!$past(cs_n) && !$past(rd_n)))
      else $error("output enable not tied to select and read");

   slave_gate_a: assert property (
      gated_data_clock |-> !$past(cs_n) && $past(slave_mode))
      else $error("data clock passed while deselected");

   range_map_a: assert property (
      ##1 range_sel == acc_range_dec($past(bip_eff), $past(span_eff)))
      else $error("range select mismatch");

   conv_finish_a: assert property (
      st_r.fsm == acc_pkg::ACC_ST_CONV && st_r.cnt != `ACC_CNT_W'(1) && pd_eff && !rst_s |=> busy)
      else $error("conversion cut short by power-down");

   no_spur_a: assert property (
      st_r.fsm == acc_pkg::ACC_ST_IDLE && !start_req |=> !busy)
      else $error("conversion started without an edge");

   hold_track_a: assert property (
      sample_hold == busy)
      else $error("hold and busy disagree");

   rd_live_a: assert property (
      s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
      else $error("read not answered");

   wr_live_a: assert property (
      s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready |=> ##1 s_axi_bvalid)
      else $error("write not answered");

   sw_src_a: assert property (
      !mode_pins.config_source_select |=> range_sel == acc_range_dec($past(cfg_q.bipolar), $past(cfg_q.span)))
      else $error("range not taken from config register");

endmodule

`default_nettype wire

// ===== logic/acc_params.svh
// Constants for the converter conversion control block
`ifndef ACC_PARAMS_SVH
`define ACC_PARAMS_SVH

// ****************************************************************
// Timing
// ****************************************************************
`define ACC_CLK_MHZ 250
`define ACC_CONV_TIME_NS 1000
`define ACC_RDC_EXT_TIME_NS 400
`define ACC_CONV_CYC ((`ACC_CONV_TIME_NS * `ACC_CLK_MHZ + 999) / 1000)
`define ACC_EXT_CYC ((`ACC_RDC_EXT_TIME_NS * `ACC_CLK_MHZ + 999) / 1000)
`define ACC_CNT_W 16

// ****************************************************************
// Widths
// ****************************************************************
`define ACC_DATA_W 14
`define ACC_CFG_W 8
`define ACC_SYNC_W 6
`define ACC_ADDR_W 8

// ****************************************************************
// Register map
// ****************************************************************
`define ACC_ADDR_CTRL 8'h00
`define ACC_ADDR_STATUS 8'h04
`define ACC_ADDR_RESULT 8'h08
`define ACC_ADDR_CFG 8'h0C
`define ACC_ADDR_COUNT 8'h10
`define ACC_CTRL_START_BIT 0
`define ACC_CTRL_PD_BIT 1
`define ACC_CTRL_RESET 2'h0
`define ACC_CFG_RESET 8'h00
`define ACC_TWOC_FLIP 14'h2000
`define ACC_RESP_OKAY 2'h0
`define ACC_RESP_SLVERR 2'h2

`endif

// ===== logic/acc_pkg.sv
// Types shared by the conversion control block
`include "acc_params.svh"
`default_nettype none

package acc_pkg;

   // ****************************************************************
   // Enumerations
   // ****************************************************************
   typedef enum logic [2:0] {
      ACC_ST_RESET = 3'h1,
      ACC_ST_IDLE = 3'h2,
      ACC_ST_CONV = 3'h4
   } acc_state_t;

   typedef enum logic [1:0] {
      ACC_RNG_0_5 = 2'h0,
      ACC_RNG_0_10 = 2'h1,
      ACC_RNG_PM5 = 2'h2,
      ACC_RNG_PM10 = 2'h3
   } acc_range_t;

   // ****************************************************************
   // Pin groups
   // ****************************************************************
   typedef struct packed {
      logic serial_parallel_select;
      logic clock_source_select;
      logic read_during_convert_select;
      logic config_source_select;
      logic output_binary_format;
      logic range_bipolar_select;
      logic range_span_select;
      logic power_down_in;
   } acc_mode_pins_t;

   typedef struct packed {
      logic config_shift_clock;
      logic config_serial_input;
      logic config_clock_edge_invert;
      logic config_port_select;
   } acc_cfg_port_t;

   typedef struct packed {
      logic [3:0] spare;
      logic obf;
      logic pd;
      logic bipolar;
      logic span;
   } acc_cfg_reg_t;

   // ****************************************************************
   // Module state
   // ****************************************************************
   typedef struct packed {
      logic [`ACC_SYNC_W-1:0] s1;
      logic [`ACC_SYNC_W-1:0] s2;
   } acc_sync_st_t;

   typedef struct packed {
      logic sclk_prev;
      acc_cfg_reg_t shreg;
   } acc_shift_st_t;

   typedef struct packed {
      acc_state_t fsm;
      logic [`ACC_CNT_W-1:0] cnt;
      logic [`ACC_DATA_W-1:0] held;
      logic [`ACC_DATA_W-1:0] result;
      logic busy;
      logic hold;
      logic oe;
      logic gclk;
      logic cnv_prev;
      logic rst_prev;
      acc_range_t range;
      logic pd_act;
      logic [1:0] ctrl;
      logic [31:0] count;
      logic aw_got;
      logic [`ACC_ADDR_W-1:0] aw_addr;
      logic w_got;
      logic [31:0] w_data;
      logic [3:0] w_strb;
      logic bvalid;
      logic [1:0] bresp;
      logic rvalid;
      logic [31:0] rdata;
      logic [1:0] rresp;
   } acc_main_st_t;

endpackage

`default_nettype wire

// ===== logic/acc_sync.sv
// Two-stage synchroniser for the asynchronous control pins
`include "acc_params.svh"
`default_nettype none

module acc_sync (
   input wire logic clk_sys,
   input wire logic nrst,
   input wire logic [`ACC_SYNC_W-1:0] d,
   output logic [`ACC_SYNC_W-1:0] q
);

   acc_pkg::acc_sync_st_t st_r;
   acc_pkg::acc_sync_st_t st_nxt;

   // ****************************************************************
   // Two flops, only the second is visible
   // ****************************************************************
   always_comb begin
      st_nxt = st_r;
      st_nxt.s1 = d;
      st_nxt.s2 = st_r.s1;
   end

   always_ff @(posedge clk_sys or negedge nrst) begin
      if (!nrst) begin
         st_r <= '0;
      end else begin
         st_r <= st_nxt;
      end
   end

   assign q = st_r.s2;

endmodule

`default_nettype wire

// ===== logic/acc_cfg_shift.sv
// Serial configuration shift register
`include "acc_params.svh"
`default_nettype none

module acc_cfg_shift (
   input wire logic clk_sys,
   input wire logic nrst,
   input wire logic sclk,
   input wire logic sdin,
   input wire logic invert,
   input wire logic enable,
   input wire logic clear,
   output acc_pkg::acc_cfg_reg_t cfg_q
);

   acc_pkg::acc_shift_st_t st_r;
   acc_pkg::acc_shift_st_t st_nxt;
   logic edge_hit;

   // ****************************************************************
   // Edge select and shift
   // ****************************************************************
   assign edge_hit = invert ? (st_r.sclk_prev & ~sclk) : (~st_r.sclk_prev & sclk);

   always_comb begin
      st_nxt = st_r;
      st_nxt.sclk_prev = sclk;
      if (clear) begin
         st_nxt.shreg = `ACC_CFG_RESET;
      end else if (enable && edge_hit) begin
         st_nxt.shreg = {st_r.shreg[`ACC_CFG_W-2:0], sdin};
      end
   end

   always_ff @(posedge clk_sys or negedge nrst) begin
      if (!nrst) begin
         st_r <= '0;
      end else begin
         st_r <= st_nxt;
      end
   end

   assign cfg_q = st_r.shreg;

   // ****************************************************************
   // Checks
   // ****************************************************************
   cfg_clear_a: assert property (@(posedge clk_sys) disable iff (!nrst) clear |=> cfg_q == '0)
      else $error("config register not cleared");
   cfg_hold_a: assert property (@(posedge clk_sys) disable iff (!nrst) !enable && !clear |=> $stable(cfg_q))
      else $error("config register moved while port deselected");

endmodule

`default_nettype wire

// ===== dv/acc_host_model.sv
// Host model driving the converter strobes and the configuration port
`default_nettype none

module acc_host_model (
   input wire logic clk_sys,
   output logic convert_start_n,
   output logic cs_n,
   output logic rd_n,
   output acc_pkg::acc_cfg_port_t cfg_port
);
   timeunit 1ns;
   timeprecision 1ps;

   initial begin
      convert_start_n = 1'b1;
      cs_n = 1'b1;
      rd_n = 1'b1;
      cfg_port = '0;
   end

   task automatic start_conv();
      @(posedge clk_sys);
      convert_start_n <= 1'b0;
      @(posedge clk_sys);
      convert_start_n <= 1'b1;
   endtask

   task automatic strobe(input logic c, input logic r);
      @(posedge clk_sys);
      cs_n <= c;
      rd_n <= r;
   endtask

   task automatic shift_cfg(input logic [7:0] v, input logic inv, input logic sel);
      @(posedge clk_sys);
      cfg_port.config_clock_edge_invert <= inv;
      cfg_port.config_port_select <= sel;
      for (int i = 7; i >= 0; i--) begin
         cfg_port.config_serial_input <= v[i] ^ inv;
         repeat (4) @(posedge clk_sys);
         cfg_port.config_shift_clock <= 1'b1;
         repeat (2) @(posedge clk_sys);
         cfg_port.config_serial_input <= ~v[i] ^ inv;
         repeat (2) @(posedge clk_sys);
         cfg_port.config_shift_clock <= 1'b0;
         repeat (4) @(posedge clk_sys);
      end
      cfg_port.config_port_select <= 1'b0;
      cfg_port.config_serial_input <= ~v[0];
   endtask
endmodule

`default_nettype wire

// ===== dv/tb_adc_conversion_control_pins.sv
// Self-checking bench for the conversion control block
`default_nettype none

module tb_adc_conversion_control_pins;
   timeunit 1ns;
   timeprecision 1ps;
   logic clk_sys = 1'b0;
   logic nrst = 1'b0;
   logic [7:0] awaddr = 8'h00;
   logic [7:0] araddr = 8'h00;
   logic [31:0] wdata = 32'h0;
   logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
   logic awready, wready, bvalid, arready, rvalid, busy, hold, doe, gclk, pda, cnv_n, cs_n, rd_n;
   logic [1:0] bresp, rresp, r;
   logic [31:0] rdata, d;
   logic reset_in = 1'b0;
   logic ext_clk = 1'b0;
   logic [13:0] code = 14'h1ABC;
   logic [13:0] dout;
   acc_pkg::acc_mode_pins_t mode = '0;
   acc_pkg::acc_cfg_port_t cfg;
   acc_pkg::acc_range_t rng;
   int num_errors = 0;
   int comparisons = 0;
   int n;

   always #2 clk_sys = ~clk_sys;

   acc_host_model host (.clk_sys(clk_sys), .convert_start_n(cnv_n), .cs_n(cs_n), .rd_n(rd_n), .cfg_port(cfg));

   acc_ctrl dut (.clk_sys(clk_sys), .nrst(nrst), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
      .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid),
      .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
      .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
      .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready), .convert_start_n(cnv_n),
      .reset_in(reset_in), .cs_n(cs_n), .rd_n(rd_n), .mode_pins(mode), .cfg_port(cfg),
      .ext_data_clock(ext_clk), .sample_code(code), .busy(busy), .sample_hold(hold), .data_out(dout),
      .data_oe(doe), .gated_data_clock(gclk), .range_sel(rng), .power_down_active(pda));

   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      comparisons++;
      if (seen !== exp) begin
         num_errors++;
         $display("MISMATCH at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask

   task automatic final_report();
      $display("comparisons %0d mismatches %0d", comparisons, num_errors);
      if (num_errors == 0 && comparisons > 0) begin
         $display("[ PASS ]");
      end else begin
         $display("[ FAIL ]");
      end
      $finish;
   endtask

   task automatic wr(input logic [7:0] a, input logic [31:0] v, input logic [1:0] er);
      logic ta, tw, tb;
      int k;
      k = 0;
      tb = 1'b0;
      @(posedge clk_sys);
      awaddr <= a;
      awvalid <= 1'b1;
      wdata <= v;
      wvalid <= 1'b1;
      bready <= 1'b1;
      while (!tb && k < 100) begin
         @(negedge clk_sys);
         ta = awvalid && awready;
         tw = wvalid && wready;
         tb = bvalid && bready;
         r = bresp;
         @(posedge clk_sys);
         if (ta) awvalid <= 1'b0;
         if (tw) wvalid <= 1'b0;
         k++;
      end
      bready <= 1'b0;
      chk(tb, 1'b1);
      chk(r, er);
   endtask

   task automatic rd(input logic [7:0] a, input logic [31:0] ev, input logic [1:0] er);
      logic ta, tr;
      int k;
      k = 0;
      tr = 1'b0;
      @(posedge clk_sys);
      araddr <= a;
      arvalid <= 1'b1;
      rready <= 1'b1;
      while (!tr && k < 100) begin
         @(negedge clk_sys);
         ta = arvalid && arready;
         tr = rvalid && rready;
         d = rdata;
         r = rresp;
         @(posedge clk_sys);
         if (ta) arvalid <= 1'b0;
         k++;
      end
      rready <= 1'b0;
      chk(tr, 1'b1);
      chk(d, ev);
      chk(r, er);
   endtask

   task automatic tick(input int c);
      repeat (c) @(negedge clk_sys);
   endtask

   // Kind 1 raises power-down and kind 2 the reset pin once busy is seen
   task automatic conv(input int kind, output int cnt);
      int w;
      w = 0;
      cnt = 0;
      host.start_conv();
      while (busy !== 1'b1 && w < 20) begin
         @(negedge clk_sys);
         w++;
      end
      if (w == 20) return;
      chk(hold, 1'b1);
      @(posedge clk_sys);
      if (kind == 1) mode.power_down_in <= 1'b1;
      if (kind == 2) reset_in <= 1'b1;
      while (busy === 1'b1 && cnt < 1000) begin
         @(negedge clk_sys);
         cnt++;
      end
   endtask

   initial begin
      #100000;
      num_errors++;
      $display("MISMATCH at %0t: watchdog expired", $time);
      final_report();
   end

   initial begin
      repeat (6) @(posedge clk_sys);
      nrst <= 1'b1;
      rd(8'h04, 32'h2, 2'h0);
      rd(8'h0C, 32'h0, 2'h0);
      rd(8'h10, 32'h0, 2'h0);
      rd(8'h14, 32'h0, 2'h2);
      wr(8'h14, 32'h2, 2'h2);
      rd(8'h00, 32'h0, 2'h0);
      wr(8'h00, 32'h2, 2'h0);
      rd(8'h00, 32'h2, 2'h0);
      tick(4);
      chk(pda, 1'b1);
      wr(8'h00, 32'h0, 2'h0);
      wr(8'h00, 32'h1, 2'h0);
      chk(busy, 1'b1);
      tick(260);
      rd(8'h10, 32'h1, 2'h0);
      $display("test registers done");
      mode.config_source_select <= 1'b1;
      mode.output_binary_format <= 1'b1;
      conv(0, n);
      chk(n, 250);
      rd(8'h08, 32'h1ABC, 2'h0);
      rd(8'h10, 32'h2, 2'h0);
      code <= 14'h0123;
      mode.output_binary_format <= 1'b0;
      conv(0, n);
      chk(n, 250);
      rd(8'h08, 32'h2123, 2'h0);
      mode.serial_parallel_select <= 1'b1;
      conv(0, n);
      chk(n, 350);
      mode.read_during_convert_select <= 1'b1;
      conv(0, n);
      chk(n, 250);
      $display("test conversions done");
      for (int i = 0; i < 4; i++) begin
         @(posedge clk_sys);
         {mode.range_bipolar_select, mode.range_span_select} <= i[1:0];
         tick(3);
         chk(rng, i);
      end
      for (int i = 0; i < 4; i++) begin
         host.strobe(i[1], i[0]);
         tick(3);
         chk(doe, i == 0);
         if (i == 0) chk(dout, 32'h2123);
      end
      @(posedge clk_sys);
      mode.clock_source_select <= 1'b1;
      ext_clk <= 1'b1;
      host.strobe(1'b0, 1'b1);
      tick(4);
      chk(gclk, 1'b1);
      host.strobe(1'b1, 1'b1);
      tick(4);
      chk(gclk, 1'b0);
      @(posedge clk_sys);
      mode.clock_source_select <= 1'b0;
      ext_clk <= 1'b0;
      $display("test range and gating done");
      conv(1, n);
      chk(n, 250);
      conv(0, n);
      chk(n, 0);
      rd(8'h10, 32'h6, 2'h0);
      rd(8'h04, 32'hE2, 2'h0);
      @(posedge clk_sys);
      mode.power_down_in <= 1'b0;
      $display("test power-down done");
      @(posedge clk_sys);
      mode.config_source_select <= 1'b0;
      host.shift_cfg(8'hA3, 1'b0, 1'b1);
      tick(4);
      rd(8'h0C, 32'hA3, 2'h0);
      chk(rng, 3);
      host.shift_cfg(8'h51, 1'b1, 1'b1);
      tick(4);
      rd(8'h0C, 32'h51, 2'h0);
      host.shift_cfg(8'hFF, 1'b0, 1'b0);
      tick(4);
      rd(8'h0C, 32'h51, 2'h0);
      $display("test configuration port done");
      @(posedge clk_sys);
      mode.config_source_select <= 1'b1;
      mode.output_binary_format <= 1'b1;
      conv(2, n);
      chk(n < 10, 1'b1);
      tick(5);
      @(posedge clk_sys);
      reset_in <= 1'b0;
      tick(8);
      rd(8'h08, 32'h0, 2'h0);
      rd(8'h10, 32'h6, 2'h0);
      rd(8'h0C, 32'h0, 2'h0);
      $display("test reset pin done");
      final_report();
   end
endmodule

`default_nettype wire
